// ### valley_switch_gate_sequencer_test.sv
// bench: start-up, valley, continuous conduction and overvoltage runs
// assumes vsgs_sequencer, vsgs_partner and the checker bound to it
`timescale 1ns/1ps
`default_nettype none
module valley_switch_gate_sequencer_test;
   localparam integer FB = 50;
   localparam integer LIM = 20 * FB;
   logic   clock = 1'b0;
   logic   rst_n = 1'b0;
   logic   start = 1'b0;
   logic   stop = 1'b0;
   logic   valleyEn = 1'b0;
   logic   ccmEn = 1'b0;
   logic   ovEn = 1'b0;
   wire logic onTe, zc, vd, oc, ov, gate, sby, vm, ovl, ccmR;
   integer failCount = 0;
   integer checkCount = 0;
   integer n, k, r;
   always #50 clock = ~clock;
   vsgs_partner partner_u (.clock(clock), .gateDrive(gate), .valleyEn(valleyEn),
      .ccmEn(ccmEn), .ovEn(ovEn), .onTimeExpired(onTe), .zeroCurrent(zc),
      .valleyDetect(vd), .overcurrentTrip(oc), .overvoltageTrip(ov));
   vsgs_sequencer #(.FALLBACK_CYC(FB)) dut_u (.clock(clock), .rst_n(rst_n),
      .supplyAboveStart(start), .supplyAboveStop(stop), .valleyDetect(vd),
      .zeroCurrent(zc), .overvoltageTrip(ov), .overcurrentTrip(oc),
      .onTimeExpired(onTe), .gateDrive(gate), .standbyMode(sby), .valleyMode(vm),
      .overvoltageLatched(ovl), .ccmReset(ccmR));
   // ************************
   // shared tasks
   // ************************
   task check(input string name, input logic seen, input logic exp);
      begin
         checkCount = checkCount + 1;
         if (seen !== exp) begin
            failCount = failCount + 1;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
         end
      end
   endtask
   task testDone;
      begin
         $display("checks %0d mismatches %0d", checkCount, failCount);
         if (failCount == 0 && checkCount > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task tick(input integer c);
      repeat (c) begin
         @(posedge clock);
         #10;
      end
   endtask
   task waitGate(input logic lvl, output integer c);
      begin
         c = 0;
         while (gate !== lvl && c < LIM) begin
            tick(1);
            c = c + 1;
         end
         if (c >= LIM) begin
            failCount = failCount + 1;
            testDone;
         end
      end
   endtask
   // ************************
   // scenarios
   // ************************
   task tStartup;
      begin
         stop = 1'b1;
         tick(20);
         check("standby", sby, 1'b1);
         check("gateIdle", gate, 1'b0);
         start = 1'b1;
         waitGate(1'b1, n);
         check("startDelay", n < 12, 1'b1);
         waitGate(1'b0, n);
         waitGate(1'b1, k);
         check("fallbackPeriod", n + k == FB, 1'b1);
         check("noValleyMode", vm, 1'b0);
      end
   endtask
   task tValley;
      begin
         valleyEn = 1'b1;
         waitGate(1'b0, n);
         waitGate(1'b1, k);
         check("valleyGap", k < FB - 10, 1'b1);
         check("valleyMode", vm, 1'b1);
         valleyEn = 1'b0;
         waitGate(1'b0, n);
         waitGate(1'b1, k);
         check("missedValley", n + k == FB, 1'b1);
      end
   endtask
   task tCcm;
      begin
         waitGate(1'b0, n);
         ccmEn = 1'b1;
         r = 0;
         k = 0;
         while (ccmR !== 1'b1 && k < LIM) begin
            n = gate;
            tick(1);
            k = k + 1;
            if (n == 1 && gate === 1'b0) ccmEn = (r != 3);
            if (n == 0 && gate === 1'b1) r = r + 1;
         end
         if (k >= LIM) begin
            failCount = failCount + 1;
            testDone;
         end
         check("ccmRises", r == 8, 1'b1);
         check("ccmPulse", ccmR, 1'b1);
         check("ccmGateOff", gate, 1'b0);
         ccmEn = 1'b0;
         tick(1);
         check("ccmStandby", sby, 1'b1);
         check("ccmPulseEnds", ccmR, 1'b0);
      end
   endtask
   task tOvervoltage;
      begin
         ovEn = 1'b1;
         k = 0;
         while (ovl !== 1'b1 && k < LIM) begin
            tick(1);
            k = k + 1;
         end
         check("ovLatch", k < LIM, 1'b1);
         if (k >= LIM) testDone;
         r = 0;
         repeat (3 * FB) begin
            tick(1);
            r = r | gate;
         end
         check("ovStaysOff", r == 0, 1'b1);
         check("ovFlag", ovl, 1'b1);
         stop = 1'b0;
         start = 1'b0;
         tick(10);
         check("ovStandby", sby, 1'b1);
         check("ovCleared", ovl, 1'b0);
         ovEn = 1'b0;
         stop = 1'b1;
         start = 1'b1;
         waitGate(1'b1, n);
         check("restart", n < 12, 1'b1);
      end
   endtask
   initial begin
      tick(4);
      rst_n = 1'b1;
      check("resetGate", gate, 1'b0);
      tStartup;
      tValley;
      tCcm;
      tOvervoltage;
      testDone;
   end
endmodule
`default_nettype wire

// ### vsgs_checker_assertions.sv
// checker: timing relations seen at the gate sequencer ports
// assumes a bind onto vsgs_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module vsgs_checker #(
   parameter integer FALLBACK_CYC = 1000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic supplyAboveStart,
   input wire logic supplyAboveStop,
   input wire logic onTimeExpired,
   input wire logic gateDrive,
   input wire logic standbyMode,
   input wire logic valleyMode,
   input wire logic overvoltageLatched,
   input wire logic ccmReset
);
   // ************************
   // run-length counters
   // ************************
   logic [15:0] lowCnt_q;
   logic [3:0]  hiCnt_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_q <= 16'h0000;
         hiCnt_q  <= 4'h0;
      end else begin
         lowCnt_q <= (gateDrive || standbyMode || overvoltageLatched) ? 16'h0000
                     : lowCnt_q + 16'h0001;
         hiCnt_q  <= (gateDrive && onTimeExpired) ? hiCnt_q + 4'h1 : 4'h0;
      end
   end
   standby_gate_a: assert property (standbyMode |-> !gateDrive)
      else $error("gate high in standby");
   start_exit_a: assert property (standbyMode && supplyAboveStart && supplyAboveStop
      |-> ##[1:8] !standbyMode) else $error("no exit from standby");
   stop_standby_a: assert property ((!supplyAboveStop)[*8]
      |-> standbyMode && !gateDrive) else $error("no standby below stop");
   // slack of two covers the synchroniser phase of the free-running timebase
   fallback_gap_a: assert property (lowCnt_q <= FALLBACK_CYC + 2)
      else $error("off time beyond timebase");
   blank_hold_a: assert property ($rose(gateDrive) && supplyAboveStop
      |-> gateDrive[*3]) else $error("on time cut in blanking");
   ontime_end_a: assert property (hiCnt_q <= 4'h8)
      else $error("on time not ended");
   ov_off_a: assert property (overvoltageLatched |-> !gateDrive)
      else $error("gate high in shutdown");
   ccm_reset_a: assert property (ccmReset |-> ##[0:1] (standbyMode && !gateDrive))
      else $error("forced reset left gate on");
   cover property ($rose(valleyMode));
   cover property (ccmReset);
   cover property ($rose(overvoltageLatched));
endmodule
bind vsgs_sequencer vsgs_checker #(.FALLBACK_CYC(FALLBACK_CYC)) chk_u (.*);
`default_nettype wire

// ### vsgs_map.vh
// vsgs_map.vh: timing constants of the valley-switch gate sequencer
// assumes a 10 MHz system clock; times are in ns, cycle counts derive from them
`ifndef VSGS_MAP_VH
`define VSGS_MAP_VH

`define VSGS_CLK_PERIOD_NS   100
// fallback timebase: 10 kHz -> period in ns
`define VSGS_FALLBACK_HZ     10000
`define VSGS_FALLBACK_NS     (1000000000 / `VSGS_FALLBACK_HZ)
`define VSGS_FALLBACK_CYC    (`VSGS_FALLBACK_NS / `VSGS_CLK_PERIOD_NS)
// blanking and detect window: 150 ns least, 250 ns most
`define VSGS_BLANK_MIN_NS    150
`define VSGS_BLANK_MAX_NS    250
`define VSGS_BLANK_CYC       ((`VSGS_BLANK_MIN_NS + `VSGS_CLK_PERIOD_NS - 1) / `VSGS_CLK_PERIOD_NS)
`define VSGS_DETECT_MIN_NS   150
`define VSGS_DETECT_MAX_NS   250
`define VSGS_DETECT_CYC      ((`VSGS_DETECT_MIN_NS + `VSGS_CLK_PERIOD_NS - 1) / `VSGS_CLK_PERIOD_NS)
// consecutive continuous-conduction cycles that force a restart
`define VSGS_CCM_LIMIT       4

`endif

// ### vsgs_partner.sv
// partner: power switch, inductor and sense comparators as levels
// assumes gateDrive from the sequencer; mode inputs from the bench
`timescale 1ns/1ps
`default_nettype none
module vsgs_partner (
   input  wire logic clock,
   input  wire logic gateDrive,
   input  wire logic valleyEn,
   input  wire logic ccmEn,
   input  wire logic ovEn,
   output wire logic onTimeExpired,
   output wire logic zeroCurrent,
   output wire logic valleyDetect,
   output wire logic overcurrentTrip,
   output wire logic overvoltageTrip
);
   // ************************
   // cycles since last gate edge
   // ************************
   logic       gate_q = 1'b0;
   logic [9:0] cnt_q = 10'h000;
   // an unknown gate before reset restarts the count instead of poisoning it
   always @(posedge clock) begin
      gate_q <= gateDrive;
      if (gateDrive == gate_q && cnt_q != 10'h3FF) begin
         cnt_q <= cnt_q + 10'h001;
      end else begin
         cnt_q <= 10'h000;
      end
   end
   assign onTimeExpired   = gateDrive && gate_q && cnt_q >= 10'h008;
   assign zeroCurrent     = !ccmEn && !gateDrive && !gate_q && cnt_q >= 10'h00A;
   // ringing gives one valley only, later the swing has died away
   assign valleyDetect    = valleyEn && zeroCurrent && cnt_q < 10'h012;
   // in continuous conduction the current never leaves the trip level
   assign overcurrentTrip = ccmEn;
   assign overvoltageTrip = ovEn && !gateDrive;
endmodule
`default_nettype wire

// ### vsgs_sequencer.v
// vsgs_sequencer.v: sequencing and protection of the power-switch gate drive
// assumes analog comparators deliver levels on pins; one 10 MHz clock; rst_n on supply start
// every comparator level passes a three-stage filter, so reactions lag by about four cycles
// all outputs come from flip-flops, so the gate never carries a decode glitch
// Operation
// - supply below start threshold: standby, gate held low
// - after standby, cycles launched from internal 10 kHz timebase
// - after first valley, cycles follow detected valleys
// - supply below stop threshold: stop, standby, restart at start threshold
// - valley indication evaluated only while gate is low
// - in valley mode, gate on at first valley after current reaches zero
// - no valley: next cycle started by the 10 kHz timebase
// - overvoltage while gate low shuts switching down, gate low
// - after overvoltage stay off until stop threshold, then standby and restart
// - each gate rising edge starts blanking; overcurrent result ignored
// - detect window after blanking; trip marks cycle continuous conduction
// - four consecutive continuous-conduction cycles: gate off, full reset
// - blanking lasts between 150 and 250 ns
// - detect window lasts between 150 and 250 ns
`timescale 1ns/1ps
`default_nettype none
`include "vsgs_map.vh"
module vsgs_sequencer #(
   parameter integer FALLBACK_CYC = `VSGS_FALLBACK_CYC,
   parameter integer BLANK_CYC    = `VSGS_BLANK_CYC,
   parameter integer DETECT_CYC   = `VSGS_DETECT_CYC,
   parameter integer CCM_LIMIT    = `VSGS_CCM_LIMIT
) (
   input  wire clock,
   input  wire rst_n,
   input  wire supplyAboveStart,
   input  wire supplyAboveStop,
   input  wire valleyDetect,
   input  wire zeroCurrent,
   input  wire overvoltageTrip,
   input  wire overcurrentTrip,
   input  wire onTimeExpired,
   output reg  gateDrive,
   output reg  standbyMode,
   output reg  valleyMode,
   output reg  overvoltageLatched,
   output reg  ccmReset
);
   // ************************************************************
   // state codes
   // ************************************************************
   localparam [2:0] ST_STANDBY = 3'h0;
   localparam [2:0] ST_OFF     = 3'h1;
   localparam [2:0] ST_ON      = 3'h2;
   localparam [2:0] ST_OVP     = 3'h3;
   localparam [2:0] ST_POR     = 3'h4;

   // ************************************************************
   // counter widths and end counts
   // ************************************************************
   // the timebase counter limits FALLBACK_CYC to 65536 cycles
   localparam integer TB_W  = 16;
   localparam integer WIN_W = 8;
   // integer parameters are cut to the counter widths on purpose
   localparam integer TB_LAST_I  = FALLBACK_CYC - 1;
   localparam integer BLANK_N_I  = BLANK_CYC;
   localparam integer DET_N_I    = DETECT_CYC;
   localparam integer CCM_LAST_I = CCM_LIMIT - 1;
   localparam [TB_W-1:0]  TB_LAST  = TB_LAST_I[TB_W-1:0];
   localparam [WIN_W-1:0] BLANK_N  = BLANK_N_I[WIN_W-1:0];
   localparam [WIN_W-1:0] DET_N    = DET_N_I[WIN_W-1:0];
   localparam [2:0]       CCM_LAST = CCM_LAST_I[2:0];

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // each pin is filtered on its own, so two pins that change together may
   // be seen a cycle apart
   wire startS;
   wire stopS;
   wire valleyS;
   wire zeroS;
   wire ovpS;
   wire ocpS;
   wire tonS;

   vsgs_sync3 uStart (.clock(clock), .rst_n(rst_n), .pinIn(supplyAboveStart), .syncOut(startS));
   vsgs_sync3 uStop  (.clock(clock), .rst_n(rst_n), .pinIn(supplyAboveStop),  .syncOut(stopS));
   vsgs_sync3 uVal   (.clock(clock), .rst_n(rst_n), .pinIn(valleyDetect),     .syncOut(valleyS));
   vsgs_sync3 uZero  (.clock(clock), .rst_n(rst_n), .pinIn(zeroCurrent),      .syncOut(zeroS));
   vsgs_sync3 uOvp   (.clock(clock), .rst_n(rst_n), .pinIn(overvoltageTrip),  .syncOut(ovpS));
   vsgs_sync3 uOcp   (.clock(clock), .rst_n(rst_n), .pinIn(overcurrentTrip),  .syncOut(ocpS));
   vsgs_sync3 uTon   (.clock(clock), .rst_n(rst_n), .pinIn(onTimeExpired),    .syncOut(tonS));

   // ************************************************************
   // registers
   // ************************************************************
   reg [2:0]       state_q;
   reg [2:0]       state_d;
   reg [TB_W-1:0]  tb_q;
   reg [TB_W-1:0]  tb_d;
   reg [WIN_W-1:0] win_q;
   reg [WIN_W-1:0] win_d;
   reg [1:0]       phase_q;
   reg [1:0]       phase_d;
   reg             trip_q;
   reg             trip_d;
   reg [2:0]       ccm_q;
   reg [2:0]       ccm_d;
   reg             valley_q;
   reg             valley_d;
   reg             zeroSeen_q;
   reg             zeroSeen_d;

   // ************************************************************
   // on-time phases and derived flags
   // ************************************************************
   // phase within the on-time: blank, detect, then sense done
   localparam [1:0] PH_BLANK  = 2'h0;
   localparam [1:0] PH_DETECT = 2'h1;
   localparam [1:0] PH_DONE   = 2'h2;

   // the timebase also runs through the on-time, so a long pulse cannot
   // stretch the off-time past one period
   wire tbExpired = (tb_q == TB_LAST);
   // the valley comparator counts only in the off state, never during the on-time
   wire valleyOff = (state_q == ST_OFF) & valleyS;
   // the current comparator counts only in the detect window, so the turn-on spike is lost
   wire ocpWindow = (state_q == ST_ON) & (phase_q == PH_DETECT) & ocpS;
   // ccm cycles counted when the on-time closes, so a cycle counts once
   wire cycleCcm  = trip_q | ocpWindow;

   // ************************************************************
   // next-state logic
   // ************************************************************
   // one case per state; every path starts from the held values set at the top
   always @* begin
      state_d    = state_q;
      tb_d       = tb_q;
      win_d      = win_q;
      phase_d    = phase_q;
      trip_d     = trip_q;
      ccm_d      = ccm_q;
      valley_d   = valley_q;
      zeroSeen_d = zeroSeen_q;
      case (state_q)
         ST_STANDBY: begin
            // counters start clean so every start-up is the same
            tb_d       = {TB_W{1'b0}};
            valley_d   = 1'b0;
            ccm_d      = 3'h0;
            zeroSeen_d = 1'b0;
            if (startS) begin
               state_d    = ST_ON;
               win_d      = {WIN_W{1'b0}};
               phase_d    = PH_BLANK;
               trip_d     = 1'b0;
            end
         end

         ST_ON: begin
            tb_d = tbExpired ? {TB_W{1'b0}} : tb_q + 1'b1;
            case (phase_q)
               PH_BLANK: begin
                  // comparator ignored while blanking
                  if (win_q == BLANK_N - 1'b1) begin
                     win_d   = {WIN_W{1'b0}};
                     phase_d = PH_DETECT;
                  end else begin
                     win_d = win_q + 1'b1;
                  end
               end
               PH_DETECT: begin
                  if (ocpWindow) begin
                     trip_d = 1'b1;
                  end
                  if (win_q == DET_N - 1'b1) begin
                     phase_d = PH_DONE;
                  end else begin
                     win_d = win_q + 1'b1;
                  end
               end
               default: begin
                  // sensing is over; the pulse waits for the on-time indication
                  phase_d = PH_DONE;
               end
            endcase

            // on-time ends only after the detect window so each cycle is judged
            if (tonS && phase_q == PH_DONE) begin
               zeroSeen_d = 1'b0;
               if (cycleCcm) begin
                  // the fourth marked cycle in a row forces the full reset
                  if (ccm_q == CCM_LAST) begin
                     state_d = ST_POR;
                  end else begin
                     ccm_d   = ccm_q + 1'b1;
                     state_d = ST_OFF;
                  end
               end else begin
                  // a clean cycle breaks the run of continuous conduction
                  ccm_d   = 3'h0;
                  state_d = ST_OFF;
               end
            end

            // the stop threshold wins even over blanking; a cut pulse is not counted
            if (!stopS) begin
               state_d = ST_STANDBY;
            end
         end

         ST_OFF: begin
            tb_d = tbExpired ? {TB_W{1'b0}} : tb_q + 1'b1;
            // zero current is remembered, since the valley follows it a few cycles later
            if (zeroS) begin
               zeroSeen_d = 1'b1;
            end
            // a fresh pulse always starts in blanking
            win_d   = {WIN_W{1'b0}};
            phase_d = PH_BLANK;
            trip_d  = 1'b0;
            if (!stopS) begin
               state_d = ST_STANDBY;
            end else if (ovpS) begin
               state_d = ST_OVP;
            end else if (valleyOff && (zeroSeen_q || zeroS)) begin
               valley_d = 1'b1;
               tb_d     = {TB_W{1'b0}};
               state_d  = ST_ON;
            end else if (tbExpired) begin
               state_d = ST_ON;
            end
         end

         ST_OVP: begin
            // stays off; the supply decays to the stop threshold
            // the timebase is frozen; the restart begins from standby anyway
            if (!stopS) begin
               state_d = ST_STANDBY;
            end
         end

         ST_POR: begin
            // one cycle with gate low, then start over from standby
            ccm_d      = 3'h0;
            valley_d   = 1'b0;
            state_d    = ST_STANDBY;
         end

         default: begin
            // unused codes fall back to standby with the gate low
            state_d = ST_STANDBY;
         end
      endcase
   end

   // ************************************************************
   // state registers
   // ************************************************************
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_STANDBY;
         tb_q       <= {TB_W{1'b0}};
         win_q      <= {WIN_W{1'b0}};
         phase_q    <= PH_BLANK;
         trip_q     <= 1'b0;
         ccm_q      <= 3'h0;
         valley_q   <= 1'b0;
         zeroSeen_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         tb_q       <= tb_d;
         win_q      <= win_d;
         phase_q    <= phase_d;
         trip_q     <= trip_d;
         ccm_q      <= ccm_d;
         valley_q   <= valley_d;
         zeroSeen_q <= zeroSeen_d;
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gateDrive          <= 1'b0;
         standbyMode        <= 1'b1;
         valleyMode         <= 1'b0;
         overvoltageLatched <= 1'b0;
         ccmReset           <= 1'b0;
      end else begin
         // decoded from the next state so the gate moves with the state, no lag
         gateDrive          <= (state_d == ST_ON);
         standbyMode        <= (state_d == ST_STANDBY);
         valleyMode         <= valley_d;
         // stands for the whole shutdown, until the stop threshold
         overvoltageLatched <= (state_d == ST_OVP);
         // one-cycle pulse: the reset state always leaves on the next edge
         ccmReset           <= (state_d == ST_POR);
      end
   end
endmodule
`default_nettype wire

// ### vsgs_sync3.v
// vsgs_sync3.v: three-stage synchroniser with agreement filter
// assumes an asynchronous pin input; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module vsgs_sync3 (
   input  wire clock,
   input  wire rst_n,
   input  wire pinIn,
   output reg  syncOut
);
   reg s1Q;
   reg s2Q;
   reg s3Q;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1Q     <= 1'b0;
         s2Q     <= 1'b0;
         s3Q     <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         s1Q <= pinIn;
         s2Q <= s1Q;
         s3Q <= s2Q;
         if (s2Q == s3Q) begin
            syncOut <= s3Q;
         end
      end
   end
endmodule
`default_nettype wire
